// ==== core/power_mgmt_status_regs.sv ====
`default_nettype none
module power_mgmt_status_regs
  import pm_regs_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     rst,
  input  wire reg_req_s req,
  input  wire pm_evt_s  evt,
  output logic [31:0]   rdata,
  output logic          clk_stop_en,
  output logic          packet_serial_out
);
  logic [2:0]  status_r;
  logic [7:0]  pkt_ctrl_r;
  logic [7:0]  clk_stop_r;
  logic [7:0]  pkt_data_r;
  logic [31:0] range_base_r;
  logic [31:0] range_mask_r;
  logic        pkt_done;
  logic        range_hit;
  logic [2:0]  flag_set;
  logic [2:0]  flag_clr;
  logic [7:0]  pkt_set;

  function automatic logic win_hit(input reg_req_s r, input logic [15:0] ofs);
    win_hit = !r.special && (r.addr[15:0] == ofs);
  endfunction

  // Any implemented window register; other offsets are silently ignored
  function automatic logic win_any(input reg_req_s r);
    win_any = win_hit(r, OFS_STATUS) || win_hit(r, OFS_PKT_CTRL) ||
              win_hit(r, OFS_CLK_STOP) || win_hit(r, OFS_PKT_DATA);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Range decode; a set mask bit takes part in the compare
  assign range_hit = evt.mem_valid &&
                     (((evt.mem_addr ^ range_base_r) & range_mask_r) == 32'h00000000);

  // Special-cycle registers, never reachable through the window
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      range_base_r <= RST_RANGE;
      range_mask_r <= RST_RANGE;
    end else if (req.wr && req.special) begin
      if (req.addr == ADR_RANGE_BASE) range_base_r <= req.wdata;
      if (req.addr == ADR_RANGE_MASK) range_mask_r <= req.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky trap flags
  assign flag_set = {evt.vga_mem_trap, evt.vga_io_trap, evt.mgmt_pin};
  assign flag_clr = (req.wr && win_hit(req, OFS_STATUS)) ? req.wdata[2:0] : 3'h0;

  // Set term ORed last so a same-cycle event is never lost
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_r <= 3'h0;
    end else begin
      status_r <= (status_r & ~flag_clr) | flag_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control and clock-stop registers, low byte implemented
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pkt_ctrl_r <= RST_BYTE;
      clk_stop_r <= RST_BYTE;
    end else if (req.wr) begin
      if (win_hit(req, OFS_PKT_CTRL)) pkt_ctrl_r <= req.wdata[7:0];
      if (win_hit(req, OFS_CLK_STOP)) clk_stop_r <= req.wdata[7:0];
    end
  end
  assign clk_stop_en = clk_stop_r[BIT_CLK_STOP];

  ////////////////////////////////////////////////////////////////////////////
  // Packet accumulation; enabled events only, bit 1 from range decode
  // Bit 1 is never gated, so a range hit reaches every packet
  always_comb begin
    pkt_set = evt.cpu_events & pkt_ctrl_r & ~8'h18;
    pkt_set[BIT_RANGE_HIT] = range_hit;
  end

  // Clear on capture, but a new event in that cycle survives
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pkt_data_r <= RST_BYTE;
    end else if (req.wr && win_hit(req, OFS_PKT_DATA)) begin
      pkt_data_r <= req.wdata[7:0] | pkt_set;
    end else if (pkt_done) begin
      pkt_data_r <= pkt_set;
    end else begin
      pkt_data_r <= pkt_data_r | pkt_set;
    end
  end

  packet_shifter #(
    .W (PKT_BITS)
  ) u_shift (
    .clk               (clk),
    .rst               (rst),
    .ivl_sel           (pkt_ctrl_r[FLD_IVL_LO +: 2]),
    .pkt               (pkt_data_r),
    .pkt_done          (pkt_done),
    .packet_serial_out (packet_serial_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read data, registered; reserved bits read zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 32'h00000000;
    end else if (req.rd) begin
      rdata <= 32'h00000000;
      if (req.special) begin
        if (req.addr == ADR_RANGE_BASE) rdata <= range_base_r;
        if (req.addr == ADR_RANGE_MASK) rdata <= range_mask_r;
      end else begin
        if (win_hit(req, OFS_STATUS))   rdata <= {29'h0, status_r};
        if (win_hit(req, OFS_PKT_CTRL)) rdata <= {24'h0, pkt_ctrl_r};
        if (win_hit(req, OFS_CLK_STOP)) rdata <= {24'h0, clk_stop_r};
        if (win_hit(req, OFS_PKT_DATA)) rdata <= {24'h0, pkt_data_r};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags: set by their own source only, cleared only by a one
  a_flag_sticky: assert property (@(posedge clk) disable iff (rst)
    status_r[BIT_MEM] && !flag_clr[BIT_MEM] |=> status_r[BIT_MEM])
    else $error("memory trap flag dropped without clear");
  a_set_wins: assert property (@(posedge clk) disable iff (rst)
    evt.vga_io_trap |=> status_r[BIT_IO])
    else $error("I/O trap event lost");
  a_pin_flag: assert property (@(posedge clk) disable iff (rst)
    evt.mgmt_pin |=> status_r[BIT_PIN])
    else $error("pin flag not set");
  a_clear_one: assert property (@(posedge clk) disable iff (rst)
    flag_clr[BIT_MEM] && !evt.vga_mem_trap |=> !status_r[BIT_MEM])
    else $error("write one did not clear flag");
  a_mem_set: assert property (@(posedge clk) disable iff (rst)
    evt.vga_mem_trap |=> status_r[BIT_MEM])
    else $error("memory trap flag not set");
  a_mem_quiet: assert property (@(posedge clk) disable iff (rst)
    !status_r[BIT_MEM] && !evt.vga_mem_trap |=> !status_r[BIT_MEM])
    else $error("memory trap flag set without event");
  a_io_quiet: assert property (@(posedge clk) disable iff (rst)
    !status_r[BIT_IO] && !evt.vga_io_trap |=> !status_r[BIT_IO])
    else $error("I/O trap flag set without event");
  a_pin_quiet: assert property (@(posedge clk) disable iff (rst)
    !status_r[BIT_PIN] && !evt.mgmt_pin |=> !status_r[BIT_PIN])
    else $error("pin flag set without event");
  a_io_sticky: assert property (@(posedge clk) disable iff (rst)
    status_r[BIT_IO] && !flag_clr[BIT_IO] |=> status_r[BIT_IO])
    else $error("I/O trap flag dropped without clear");
  a_pin_sticky: assert property (@(posedge clk) disable iff (rst)
    status_r[BIT_PIN] && !flag_clr[BIT_PIN] |=> status_r[BIT_PIN])
    else $error("pin flag dropped without clear");
  a_io_clear: assert property (@(posedge clk) disable iff (rst)
    flag_clr[BIT_IO] && !evt.vga_io_trap |=> !status_r[BIT_IO])
    else $error("write one did not clear I/O flag");
  a_pin_clear: assert property (@(posedge clk) disable iff (rst)
    flag_clr[BIT_PIN] && !evt.mgmt_pin |=> !status_r[BIT_PIN])
    else $error("write one did not clear pin flag");

  // Packet register: events accumulate, capture empties it
  a_range_bit: assert property (@(posedge clk) disable iff (rst)
    range_hit && !pkt_done |=> pkt_data_r[BIT_RANGE_HIT])
    else $error("range hit not recorded");
  a_pkt_clear: assert property (@(posedge clk) disable iff (rst)
    pkt_done && !req.wr && pkt_set == 8'h00 |=> pkt_data_r == 8'h00)
    else $error("packet not cleared after capture");
  a_pkt_accum: assert property (@(posedge clk) disable iff (rst)
    !pkt_done && !(req.wr && win_hit(req, OFS_PKT_DATA)) |=>
      (pkt_data_r & $past(pkt_data_r)) == $past(pkt_data_r))
    else $error("packet bit lost before capture");

  // Register writes land next cycle and nothing else moves them
  a_base_guard: assert property (@(posedge clk) disable iff (rst)
    req.wr && !req.special |=> $stable(range_base_r) && $stable(range_mask_r))
    else $error("base or mask changed by window write");
  a_base_write: assert property (@(posedge clk) disable iff (rst)
    req.wr && req.special && req.addr == ADR_RANGE_BASE |=> range_base_r == $past(req.wdata))
    else $error("base write not taken");
  a_mask_write: assert property (@(posedge clk) disable iff (rst)
    req.wr && req.special && req.addr == ADR_RANGE_MASK |=> range_mask_r == $past(req.wdata))
    else $error("mask write not taken");
  a_ctrl_write: assert property (@(posedge clk) disable iff (rst)
    req.wr && win_hit(req, OFS_PKT_CTRL) |=> pkt_ctrl_r == $past(req.wdata[7:0]))
    else $error("control write not taken");
  a_ctrl_hold: assert property (@(posedge clk) disable iff (rst)
    !(req.wr && win_hit(req, OFS_PKT_CTRL)) |=> $stable(pkt_ctrl_r))
    else $error("control changed without write");
  a_cstop_write: assert property (@(posedge clk) disable iff (rst)
    req.wr && win_hit(req, OFS_CLK_STOP) |=> clk_stop_r == $past(req.wdata[7:0]))
    else $error("clock-stop write not taken");
  a_cstop_hold: assert property (@(posedge clk) disable iff (rst)
    !(req.wr && win_hit(req, OFS_CLK_STOP)) |=> $stable(clk_stop_en))
    else $error("suspend enable changed without write");
  a_wr_unmapped: assert property (@(posedge clk) disable iff (rst)
    req.wr && !req.special && !win_any(req) |=> $stable(pkt_ctrl_r) && $stable(clk_stop_r))
    else $error("unmapped window write changed a register");

  // Read data one cycle after the strobe
  a_status_read: assert property (@(posedge clk) disable iff (rst)
    req.rd && win_hit(req, OFS_STATUS) |=> rdata[31:3] == 29'h0 && rdata[2:0] == $past(status_r))
    else $error("status read mismatch");
  a_rd_ctrl: assert property (@(posedge clk) disable iff (rst)
    req.rd && win_hit(req, OFS_PKT_CTRL) |=> rdata == {24'h0, $past(pkt_ctrl_r)})
    else $error("control read mismatch");
  a_rd_pkt: assert property (@(posedge clk) disable iff (rst)
    req.rd && win_hit(req, OFS_PKT_DATA) |=> rdata == {24'h0, $past(pkt_data_r)})
    else $error("packet read mismatch");
  a_rd_base: assert property (@(posedge clk) disable iff (rst)
    req.rd && req.special && req.addr == ADR_RANGE_BASE |=> rdata == $past(range_base_r))
    else $error("base read mismatch");
  a_rd_unmapped: assert property (@(posedge clk) disable iff (rst)
    req.rd && !req.special && !win_any(req) |=> rdata == 32'h00000000)
    else $error("unmapped window read not zero");
endmodule
`default_nettype wire

// ==== core/pm_regs_pkg.sv ====
`default_nettype none
package pm_regs_pkg;
  // Memory-mapped window above the control register base
  localparam logic [15:0] WIN_LO           = 16'h8500;
  localparam logic [15:0] WIN_HI           = 16'h8fff;
  localparam logic [15:0] OFS_STATUS       = 16'h8500;
  localparam logic [15:0] OFS_PKT_CTRL     = 16'h8504;
  localparam logic [15:0] OFS_CLK_STOP     = 16'h8508;
  localparam logic [15:0] OFS_PKT_DATA     = 16'h850c;
  // Special-instruction register addresses
  localparam logic [31:0] ADR_RANGE_BASE   = 32'hffffff6c;
  localparam logic [31:0] ADR_RANGE_MASK   = 32'hffffff7c;
  // Status flag positions
  localparam int          BIT_PIN          = 0;
  localparam int          BIT_IO           = 1;
  localparam int          BIT_MEM          = 2;
  // Packet bit set by a range hit
  localparam int          BIT_RANGE_HIT    = 1;
  // Control fields
  localparam int          FLD_IVL_LO       = 3;
  localparam int          BIT_CLK_STOP     = 0;
  // Reset values
  localparam logic [7:0]  RST_BYTE         = 8'h00;
  localparam logic [31:0] RST_RANGE        = 32'h00000000;
  // Packet framing in clocks
  localparam int          START_CLKS       = 2;
  localparam int          STOP_CLKS        = 1;
  localparam int          PKT_BITS         = 8;
  // Transmission interval choices in ns
  localparam int          CLK_NS           = 40;
  localparam int          IVL0_NS          = 1000;
  localparam int          IVL1_NS          = 2500;
  localparam int          IVL2_NS          = 5000;
  localparam int          IVL3_NS          = 10000;
  localparam logic [8:0]  IVL0_CLKS        = 9'((IVL0_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [8:0]  IVL1_CLKS        = 9'((IVL1_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [8:0]  IVL2_CLKS        = 9'((IVL2_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [8:0]  IVL3_CLKS        = 9'((IVL3_NS + CLK_NS - 1) / CLK_NS);

  // Register access request from the core
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic        special;
    logic [31:0] addr;
    logic [31:0] wdata;
  } reg_req_s;

  // Trap and event sources
  typedef struct packed {
    logic        vga_mem_trap;
    logic        vga_io_trap;
    logic        mgmt_pin;
    logic        mem_valid;
    logic [31:0] mem_addr;
    logic [7:0]  cpu_events;
  } pm_evt_s;

  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_e;
endpackage
`default_nettype wire

// ==== core/packet_shifter.sv ====
`default_nettype none
module packet_shifter
  import pm_regs_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [1:0]   ivl_sel,
  input  wire logic [W-1:0] pkt,
  output logic              pkt_done,
  output logic              packet_serial_out
);
  tx_state_e   st_r;
  logic [8:0]  ivl_cnt_r;
  logic [3:0]  cnt_r;
  logic [W-1:0] sh_r;

  function automatic logic [8:0] ivl_clks(input logic [1:0] s);
    case (s)
      2'h0:    ivl_clks = IVL0_CLKS;
      2'h1:    ivl_clks = IVL1_CLKS;
      2'h2:    ivl_clks = IVL2_CLKS;
      default: ivl_clks = IVL3_CLKS;
    endcase
  endfunction

  // Interval wait, start pair, data MSB first, stop bit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r      <= TX_IDLE;
      ivl_cnt_r <= 9'h000;
      cnt_r     <= 4'h0;
      sh_r      <= '0;
      packet_serial_out <= 1'b0;
    end else begin
      case (st_r)
        TX_IDLE: begin
          packet_serial_out <= 1'b0;
          if (ivl_cnt_r >= ivl_clks(ivl_sel) - 9'h001) begin
            ivl_cnt_r <= 9'h000;
            st_r      <= TX_START;
            cnt_r     <= 4'h0;
            packet_serial_out <= 1'b1;
          end else begin
            ivl_cnt_r <= ivl_cnt_r + 9'h001;
          end
        end
        TX_START: begin
          // Sample packet late so events in the first start clock are carried
          packet_serial_out <= 1'b1;
          // Leave only after the second high clock, else the start pair is one clock short
          if (cnt_r == 4'(START_CLKS - 1)) begin
            st_r  <= TX_DATA;
            cnt_r <= 4'h0;
            sh_r  <= {pkt[W-2:0], 1'b0};
            packet_serial_out <= pkt[W-1];
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
        TX_DATA: begin
          if (cnt_r == 4'(W - 1)) begin
            st_r <= TX_STOP;
            packet_serial_out <= 1'b1;
          end else begin
            cnt_r <= cnt_r + 4'h1;
            packet_serial_out <= sh_r[W-1];
            sh_r  <= {sh_r[W-2:0], 1'b0};
          end
        end
        TX_STOP: begin
          st_r <= TX_IDLE;
          packet_serial_out <= 1'b0;
        end
        default: st_r <= TX_IDLE;
      endcase
    end
  end

  // Packet captured at start-to-data hand-off
  assign pkt_done = (st_r == TX_START) && (cnt_r == 4'(START_CLKS - 1));

  a_stop_low: assert property (@(posedge clk) disable iff (rst)
    st_r == TX_STOP |=> packet_serial_out == 1'b0)
    else $error("serial out not low after stop bit");
  a_start_high: assert property (@(posedge clk) disable iff (rst)
    $rose(st_r == TX_START) |-> packet_serial_out ##1 packet_serial_out)
    else $error("start pair not two high clocks");
endmodule
`default_nettype wire

// ==== tb/packet_receiver.sv ====
`default_nettype none
module packet_receiver (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       companion_packet_in,
  output logic [7:0]      last_pkt,
  output int              n_pkts,
  output int              n_bad
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_r;
  logic [7:0] shift_r;
  ////////////////////////////////////////////////////////////////
  // Frame decoder; a low second start or stop bit is a bad frame
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 4'h0;
      shift_r <= 8'h00;
      last_pkt <= 8'h00;
      n_pkts <= 0;
      n_bad <= 0;
    end else if (cnt_r == 4'h0) begin
      if (companion_packet_in) cnt_r <= 4'h1;
    end else if (cnt_r == 4'h1) begin
      if (!companion_packet_in) n_bad <= n_bad + 1;
      cnt_r <= 4'h2;
    end else if (cnt_r < 4'ha) begin
      shift_r <= {shift_r[6:0], companion_packet_in};
      cnt_r <= cnt_r + 4'h1;
    end else begin
      if (!companion_packet_in) n_bad <= n_bad + 1;
      last_pkt <= shift_r;
      n_pkts <= n_pkts + 1;
      cnt_r <= 4'h0;
    end
  end
endmodule
`default_nettype wire

// ==== tb/power_mgmt_status_regs_tb.sv ====
`default_nettype none
module power_mgmt_status_regs_tb;
  import pm_regs_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  reg_req_s    req = '0;
  pm_evt_s     evt = '0;
  logic [31:0] rdata;
  logic        clk_stop_en;
  logic        line;
  logic [7:0]  last_pkt;
  int          n_pkts;
  int          n_bad;
  int          n_errors = 0;
  int          samples_checked = 0;
  always #20 clk = ~clk;
  power_mgmt_status_regs i_power_mgmt_status_regs (.clk(clk), .rst(rst), .req(req), .evt(evt), .rdata(rdata),
    .clk_stop_en(clk_stop_en), .packet_serial_out(line));
  packet_receiver i_packet_receiver (.clk(clk), .rst(rst), .companion_packet_in(line), .last_pkt(last_pkt),
    .n_pkts(n_pkts), .n_bad(n_bad));
  ////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One bus and event cycle, then back to idle so strobes stay one clock
  task automatic cyc(input reg_req_s r, input pm_evt_s e);
    @(posedge clk);
    req <= r;
    evt <= e;
    @(posedge clk);
    req <= '0;
    evt <= '0;
  endtask
  task automatic wr_reg(input logic sp, input logic [31:0] a, input logic [31:0] d);
    cyc('{1'b1, 1'b0, sp, a, d}, '0);
  endtask
  // Data is registered at the taking edge, so look just after it
  task automatic rd_reg(input logic sp, input logic [31:0] a, input logic [31:0] exp);
    cyc('{1'b0, 1'b1, sp, a, 32'h0}, '0);
    #1;
    chk(rdata, exp);
  endtask
  // Bounded wait for the receiver to finish one more frame
  task automatic wait_frame(output int n);
    int s;
    s = n_pkts;
    n = 0;
    while (n_pkts == s) begin
      @(posedge clk);
      n++;
      if (n > 1000) begin
        n_errors++;
        $display("[ERR] %0t no frame", $time);
        conclude();
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    int n;
    pm_evt_s e;
    logic [8:0] ivl [4];
    logic [15:0] ofs [4];
    ivl = '{IVL0_CLKS, IVL1_CLKS, IVL2_CLKS, IVL3_CLKS};
    ofs = '{OFS_STATUS, OFS_PKT_CTRL, OFS_CLK_STOP, OFS_PKT_DATA};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    // Reset values of the whole register table
    for (int i = 0; i < 4; i++) rd_reg(1'b0, {16'h0, ofs[i]}, 32'h0);
    rd_reg(1'b1, ADR_RANGE_BASE, RST_RANGE);
    rd_reg(1'b1, ADR_RANGE_MASK, RST_RANGE);
    chk(clk_stop_en, 1'b0);
    // Each trap source sets its own sticky flag
    for (int b = 0; b < 3; b++) begin
      e = '0;
      e.mgmt_pin = (b == BIT_PIN);
      e.vga_io_trap = (b == BIT_IO);
      e.vga_mem_trap = (b == BIT_MEM);
      cyc('0, e);
      rd_reg(1'b0, {16'h0, OFS_STATUS}, (32'h2 << b) - 32'h1);
    end
    wr_reg(1'b0, {16'h0, OFS_STATUS}, 32'h0);
    rd_reg(1'b0, {16'h0, OFS_STATUS}, 32'h7);
    wr_reg(1'b0, {16'h0, OFS_STATUS}, 32'h4);
    rd_reg(1'b0, {16'h0, OFS_STATUS}, 32'h3);
    e = '0;
    e.vga_io_trap = 1'b1;
    cyc('{1'b1, 1'b0, 1'b0, {16'h0, OFS_STATUS}, 32'h2}, e);
    rd_reg(1'b0, {16'h0, OFS_STATUS}, 32'h3);
    wr_reg(1'b0, {16'h0, OFS_STATUS}, 32'h3);
    rd_reg(1'b0, {16'h0, OFS_STATUS}, 32'h0);
    // Control readback; unused window offset and non-special base reach ignored
    wr_reg(1'b0, {16'h0, OFS_PKT_CTRL}, 32'h98);
    wr_reg(1'b0, 32'h8510, 32'hff);
    rd_reg(1'b0, 32'h8510, 32'h0);
    rd_reg(1'b0, {16'h0, OFS_PKT_CTRL}, 32'h98);
    wr_reg(1'b0, ADR_RANGE_BASE, 32'h5);
    rd_reg(1'b1, ADR_RANGE_BASE, 32'h0);
    wr_reg(1'b0, {16'h0, OFS_CLK_STOP}, 32'h1);
    #1 chk(clk_stop_en, 1'b1);
    wr_reg(1'b0, {16'h0, OFS_CLK_STOP}, 32'h0);
    #1 chk(clk_stop_en, 1'b0);
    wr_reg(1'b1, ADR_RANGE_BASE, 32'h12340000);
    wr_reg(1'b1, ADR_RANGE_MASK, 32'hffff0000);
    rd_reg(1'b1, ADR_RANGE_BASE, 32'h12340000);
    rd_reg(1'b1, ADR_RANGE_MASK, 32'hffff0000);
    // Miss plus gated events, then a hit, then the frame on the wire
    wait_frame(n);
    cyc('0, '{1'b0, 1'b0, 1'b0, 1'b1, 32'h12350000, 8'h81});
    rd_reg(1'b0, {16'h0, OFS_PKT_DATA}, 32'h80);
    cyc('0, '{1'b0, 1'b0, 1'b0, 1'b1, 32'h12345678, 8'h00});
    rd_reg(1'b0, {16'h0, OFS_PKT_DATA}, 32'h82);
    wait_frame(n);
    chk(last_pkt, 8'h82);
    rd_reg(1'b0, {16'h0, OFS_PKT_DATA}, 32'h0);
    // Frame spacing for every interval code
    for (int c = 0; c < 4; c++) begin
      wr_reg(1'b0, {16'h0, OFS_PKT_CTRL}, 32'(c) << FLD_IVL_LO);
      wait_frame(n);
      wait_frame(n);
      wait_frame(n);
      chk(n, 32'(ivl[c]) + 32'(START_CLKS + PKT_BITS + STOP_CLKS));
    end
    chk(n_bad, 0);
    conclude();
  end
endmodule
`default_nettype wire
